/* File: src/hbfpl_defines.vh */
`ifndef HBFPL_DEFINES_VH
`define HBFPL_DEFINES_VH

// Clock period in ns (10 MHz)
`define HBFPL_CLK_PERIOD_NS 100
// Current-limit off-time in ns, 20 us typical
`define HBFPL_OFF_TIME_NS 20000
// Off-time in clock cycles, rounded down
`define HBFPL_OFF_CYCLES (`HBFPL_OFF_TIME_NS / `HBFPL_CLK_PERIOD_NS)
// Width of the off-time counter
`define HBFPL_OFF_CNT_W 12
// Bridge drive codes: low, high, high impedance
`define HBFPL_DRV_LOW 2'h0
`define HBFPL_DRV_HIGH 2'h1
`define HBFPL_DRV_HIZ 2'h2
// Fault latch cause codes
`define HBFPL_CAUSE_NONE 2'h0
`define HBFPL_CAUSE_SHORT 2'h1
`define HBFPL_CAUSE_OVERTEMP 2'h2

`endif

/* File: src/hbfpl_edge_detect.v */
`timescale 1ns/100ps
`include "hbfpl_defines.vh"

// Samples the two reset inputs and reports the clearing edges
module hbfpl_edge_detect
(
  // Clock and reset
  input wire sys_clk,
  input wire rst_n,
  // Sampled control inputs
  input wire disable_active_high,
  input wire enable_active_low_disable,
  // One-cycle clearing pulse
  output wire clear_edge
);

  reg dis_prev;
  reg en_prev;

  // Previous samples; reset to the idle levels so no edge fires at startup
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      dis_prev <= 1'b0;
      en_prev <= 1'b1;
    end
    else
    begin
      dis_prev <= disable_active_high;
      en_prev <= enable_active_low_disable;
    end
  end

  // Disable falling or enable rising clears a latch [RULE14] [RULE2]
  assign clear_edge = (dis_prev & ~disable_active_high) |
                      (~en_prev & enable_active_low_disable);

endmodule // hbfpl_edge_detect

/* File: src/hbfpl_off_timer.v */
`timescale 1ns/100ps
`include "hbfpl_defines.vh"

// Constant off-time timer for current limiting
module hbfpl_off_timer
(
  // Clock and reset
  input wire sys_clk,
  input wire rst_n,
  // Start pulse and load value
  input wire start,
  input wire [`HBFPL_OFF_CNT_W-1:0] load_cycles,
  // Busy while off-time runs
  output wire busy
);

  reg [`HBFPL_OFF_CNT_W-1:0] count;

  // Loads on start, counts down to zero; restart ignored while busy [RULE15]
  always @(posedge sys_clk)
  begin
    if (!rst_n)
      count <= {`HBFPL_OFF_CNT_W{1'b0}};
    else if (start && (count == {`HBFPL_OFF_CNT_W{1'b0}}))
      count <= load_cycles;
    else if (count != {`HBFPL_OFF_CNT_W{1'b0}})
      count <= count - {{(`HBFPL_OFF_CNT_W-1){1'b0}}, 1'b1};
  end

  assign busy = (count != {`HBFPL_OFF_CNT_W{1'b0}});

endmodule // hbfpl_off_timer

/* File: src/hbfpl_top.v */
`timescale 1ns/100ps
`include "hbfpl_defines.vh"

// Operation
// RULE1: Short-circuit latches both outputs off, flag low
// RULE2: Disable fall or enable rise clears latch
// RULE3: Outputs follow inputs when no fault active
// RULE4: Current limit forces outputs off for off-time
// RULE5: Above 160 C use folded-back limit
// RULE6: Overtemperature detector starts thermal shutdown
// RULE7: Overtemperature latches outputs off, flag low
// RULE8: Thermal reset re-enables only below hysteresis
// RULE9: Fault reset and power cycle clear flag
// RULE10: System limits time above 150 C
// RULE11: Lost supply puts outputs off at once
// RULE12: Undervoltage forces off, flag low, no latch
// RULE13: Polarity, disable and sleep set outputs
// RULE14: Reset edges found by sample comparison
// RULE15: Off-time timed by loaded cycle counter
module hbfpl_top
(
  // Clock and reset; reset stands for a power cycle
  input wire sys_clk,
  input wire rst_n,
  // Microcontroller control inputs
  input wire polarity_input_a,
  input wire polarity_input_b,
  input wire disable_active_high,
  input wire enable_active_low_disable,
  // Analog detector results
  input wire short_detect,
  input wire current_over_normal_limit,
  input wire current_over_foldback_limit,
  input wire temp_above_foldback,
  input wire temp_above_shutdown,
  input wire temp_below_hysteresis,
  input wire supply_undervoltage,
  input wire power_supply_input_open,
  // Off-time length in clock cycles
  input wire [`HBFPL_OFF_CNT_W-1:0] limit_off_time,
  // Bridge terminals, each with drive value and enable
  output reg bridge_terminal_a,
  output reg bridge_terminal_a_oe,
  output reg bridge_terminal_b,
  output reg bridge_terminal_b_oe,
  // Fault flag to microcontroller, low on fault
  output reg fault_flag_n,
  // Status of fault latch, off-time timer and threshold selection
  output reg [1:0] fault_cause,
  output reg limit_active,
  output reg current_limit_threshold
);

  localparam ST_RUN = 2'h0;
  localparam ST_LATCHED = 2'h1;
  localparam ST_COOLING = 2'h2;

  reg [1:0] state;
  reg [1:0] next_state;
  reg [1:0] next_cause;
  reg [1:0] cause;
  wire clear_edge;
  wire off_busy;
  wire over_limit;
  wire limit_start;
  wire latched;
  wire forced_off;
  wire flag_low;
  reg [1:0] drv_a;
  reg [1:0] drv_b;

  // Decode one polarity input into a half-bridge drive code
  function [1:0] hbfpl_half_drive;
    input pol;
    begin
      hbfpl_half_drive = pol ? `HBFPL_DRV_HIGH : `HBFPL_DRV_LOW;
    end
  endfunction

  hbfpl_edge_detect u_edge
  (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .disable_active_high(disable_active_high),
    .enable_active_low_disable(enable_active_low_disable),
    .clear_edge(clear_edge)
  );

  // Foldback: hot die compares against the lower threshold [RULE5]
  assign over_limit = temp_above_foldback ? current_over_foldback_limit
                                          : current_over_normal_limit;
  // Only starts in run state with supply present and timer idle; disable and sleep do not block it
  assign limit_start = over_limit & ~off_busy & ~forced_off; // [RULE4]

  hbfpl_off_timer u_timer
  (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .start(limit_start),
    .load_cycles(limit_off_time),
    .busy(off_busy)
  );

  // Fault latch; a new fault in the clearing cycle wins over the clear, except a short when the clear goes to cooling
  always @*
  begin
    next_state = state;
    next_cause = cause;
    case (state)
      ST_RUN:
      begin
        if (temp_above_shutdown)
        begin
          next_state = ST_LATCHED; // [RULE6] [RULE7]
          next_cause = `HBFPL_CAUSE_OVERTEMP;
        end
        else if (short_detect)
        begin
          next_state = ST_LATCHED; // [RULE1]
          next_cause = `HBFPL_CAUSE_SHORT;
        end
      end
      ST_LATCHED:
      begin
        if (clear_edge)
        begin
          if (cause == `HBFPL_CAUSE_OVERTEMP && !temp_below_hysteresis)
            next_state = ST_COOLING; // [RULE8]
          else
          begin
            next_state = ST_RUN; // [RULE2] [RULE9]
            next_cause = `HBFPL_CAUSE_NONE;
          end
        end
      end
      ST_COOLING:
      begin
        // Flag already cleared; wait for die to cool [RULE8]
        if (temp_below_hysteresis)
        begin
          next_state = ST_RUN;
          next_cause = `HBFPL_CAUSE_NONE;
        end
      end
      default:
      begin
        next_state = ST_LATCHED;
        next_cause = `HBFPL_CAUSE_NONE;
      end
    endcase
    // Fault still present when the latch would return to run wins, so the bridge never
    // drives for even one cycle into a standing short [RULE1] [RULE7]
    if (next_state != ST_LATCHED && temp_above_shutdown)
    begin
      next_state = ST_LATCHED;
      next_cause = `HBFPL_CAUSE_OVERTEMP;
    end
    else if (next_state == ST_RUN && short_detect)
    begin
      next_state = ST_LATCHED;
      next_cause = `HBFPL_CAUSE_SHORT;
    end
  end

  // Power cycle clears every latched fault [RULE9]
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state <= ST_RUN;
      cause <= `HBFPL_CAUSE_NONE;
    end
    else
    begin
      state <= next_state;
      cause <= next_cause;
    end
  end

  assign latched = (state != ST_RUN);
  // Undervoltage and open supply are levels, never latched [RULE11] [RULE12]
  assign forced_off = latched | supply_undervoltage | power_supply_input_open;
  // Flag stays high in cooling: reset already cleared it [RULE9]
  assign flag_low = (state == ST_LATCHED) | supply_undervoltage |
                    (enable_active_low_disable & disable_active_high);

  // Commanded drive per half-bridge [RULE3] [RULE13]
  always @*
  begin
    drv_a = hbfpl_half_drive(polarity_input_a);
    drv_b = hbfpl_half_drive(polarity_input_b);
    if (!enable_active_low_disable || disable_active_high)
    begin
      drv_a = `HBFPL_DRV_HIZ; // [RULE13]
      drv_b = `HBFPL_DRV_HIZ;
    end
    if (forced_off || off_busy)
    begin
      drv_a = `HBFPL_DRV_HIZ; // [RULE1] [RULE7] [RULE4] [RULE11]
      drv_b = `HBFPL_DRV_HIZ;
    end
  end

  // Registered outputs; power cycle leaves the bridge off
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      bridge_terminal_a <= 1'b0;
      bridge_terminal_a_oe <= 1'b0;
      bridge_terminal_b <= 1'b0;
      bridge_terminal_b_oe <= 1'b0;
      fault_flag_n <= 1'b1;
      fault_cause <= `HBFPL_CAUSE_NONE;
      limit_active <= 1'b0;
      current_limit_threshold <= 1'b0;
    end
    else
    begin
      bridge_terminal_a <= (drv_a == `HBFPL_DRV_HIGH);
      bridge_terminal_a_oe <= (drv_a != `HBFPL_DRV_HIZ);
      bridge_terminal_b <= (drv_b == `HBFPL_DRV_HIGH);
      bridge_terminal_b_oe <= (drv_b != `HBFPL_DRV_HIZ);
      fault_flag_n <= ~flag_low; // [RULE1] [RULE7] [RULE12]
      fault_cause <= cause;
      limit_active <= off_busy;
      current_limit_threshold <= temp_above_foldback; // [RULE5]
    end
  end

endmodule // hbfpl_top

/* File: test/hbfpl_top_asserts.sv */
`timescale 1ns/100ps
`include "hbfpl_defines.vh"

// Watches bridge outputs against detector and control inputs
module hbfpl_top_asserts
(
  // Clock and reset
  input logic sys_clk,
  input logic rst_n,
  // Control and detector inputs
  input logic polarity_input_a,
  input logic disable_active_high,
  input logic enable_active_low_disable,
  input logic short_detect,
  input logic current_over_normal_limit,
  input logic current_over_foldback_limit,
  input logic temp_above_foldback,
  input logic temp_above_shutdown,
  input logic temp_below_hysteresis,
  input logic supply_undervoltage,
  input logic power_supply_input_open,
  // Observed outputs
  input logic bridge_terminal_a,
  input logic bridge_terminal_a_oe,
  input logic bridge_terminal_b_oe,
  input logic fault_flag_n,
  input logic [1:0] fault_cause,
  input logic limit_active,
  input logic current_limit_threshold
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic off;
  logic quiet;
  // Quiet spans four cycles so fault recovery latency is allowed for
  assign off = !bridge_terminal_a_oe && !bridge_terminal_b_oe;
  assign quiet = enable_active_low_disable && !disable_active_high &&
    !short_detect && !current_over_normal_limit && !limit_active &&
    !current_over_foldback_limit && !temp_above_shutdown &&
    temp_below_hysteresis && !supply_undervoltage &&
    !power_supply_input_open && fault_cause == 2'h0;

  AST_SHORT_OFF: assert property (
    $rose(short_detect) |-> ##2 off && !fault_flag_n)
    else $error("Short did not force outputs off");
  AST_SHORT_CAUSE: assert property (
    $rose(short_detect) && !temp_above_shutdown && fault_cause == 2'h0
    |-> ##2 fault_cause == `HBFPL_CAUSE_SHORT)
    else $error("Short cause not latched");
  AST_OT_OFF: assert property (
    $rose(temp_above_shutdown) |-> ##2 off && !fault_flag_n &&
    fault_cause == `HBFPL_CAUSE_OVERTEMP)
    else $error("Overtemperature did not latch off");
  AST_LATCH_OFF: assert property (
    fault_cause != 2'h0 |-> off)
    else $error("Outputs driven while latched");
  AST_DISABLE: assert property (
    disable_active_high && enable_active_low_disable
    |=> off && !fault_flag_n)
    else $error("Disable did not release outputs");
  AST_SLEEP: assert property (
    !enable_active_low_disable |=> off)
    else $error("Sleep left outputs driven");
  AST_UNDERVOLT: assert property (
    supply_undervoltage |=> off && !fault_flag_n)
    else $error("Undervoltage not reported");
  AST_FOLLOW: assert property (
    quiet [*4] |=> bridge_terminal_a_oe &&
    bridge_terminal_a == $past(polarity_input_a))
    else $error("Output does not follow polarity");
  AST_FOLDBACK: assert property (
    1'b1 |=> current_limit_threshold == $past(temp_above_foldback))
    else $error("Threshold selection wrong");
  cover property ($rose(short_detect));
  cover property ($fell(limit_active));
  cover property ($rose(temp_above_shutdown));
endmodule // hbfpl_top_asserts

bind hbfpl_top hbfpl_top_asserts hbfpl_top_asserts_inst (.*);

/* File: test/hbfpl_mcu_model.sv */
`timescale 1ns/100ps

// Controller side: sets bridge commands, reads the fault flag
module hbfpl_mcu_model
(
  // Clock
  input logic sys_clk,
  // Commands to the bridge
  output logic polarity_input_a = 1'b0,
  output logic polarity_input_b = 1'b0,
  output logic disable_active_high = 1'b0,
  output logic enable_active_low_disable = 1'b1,
  // Fault flag read back
  input logic fault_flag_n
);
  // All command levels change together, off the clock edge
  task drive(input logic a, b, dis, en);
    polarity_input_a = a;
    polarity_input_b = b;
    disable_active_high = dis;
    enable_active_low_disable = en;
  endtask
  // Disable held high one cycle so its fall is sampled
  task pulse_disable();
    disable_active_high = 1'b1;
    @(posedge sys_clk);
    #10 disable_active_high = 1'b0;
  endtask
  // Enable held low one cycle so its rise is sampled
  task pulse_enable();
    enable_active_low_disable = 1'b0;
    @(posedge sys_clk);
    #10 enable_active_low_disable = 1'b1;
  endtask
endmodule // hbfpl_mcu_model

/* File: test/tb.sv */
`timescale 1ns/100ps
`include "hbfpl_defines.vh"

module tb;
  logic sys_clk = 1'b0, rst_n = 1'b0, short_detect = 1'b0;
  logic current_over_normal_limit = 1'b0, current_over_foldback_limit = 1'b0;
  logic temp_above_foldback = 1'b0, temp_above_shutdown = 1'b0;
  logic temp_below_hysteresis = 1'b1, supply_undervoltage = 1'b0;
  logic power_supply_input_open = 1'b0;
  logic [`HBFPL_OFF_CNT_W-1:0] limit_off_time = 12'h005;
  wire polarity_input_a, polarity_input_b, disable_active_high;
  wire enable_active_low_disable, bridge_terminal_a, bridge_terminal_a_oe;
  wire bridge_terminal_b, bridge_terminal_b_oe, fault_flag_n, limit_active;
  wire current_limit_threshold;
  wire [1:0] fault_cause;
  wire [4:0] st = {bridge_terminal_a_oe, bridge_terminal_b_oe,
    bridge_terminal_a, bridge_terminal_b, fault_flag_n};
  int num_errors = 0, check_count = 0, cycles = 0, n, m;
  hbfpl_top hbfpl_top_inst (.*);
  hbfpl_mcu_model hbfpl_mcu_model_inst (.*);

  // Clock and hang guard
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      finish_test();
    end
  end
  task finish_test();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task cyc(input int k);
    repeat (k) @(posedge sys_clk);
    #10;
  endtask
  task chk(input string nm, input logic [4:0] seen, exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task t_cmds();
    for (int i = 0; i < 4; i++)
    begin
      hbfpl_mcu_model_inst.drive(i[1], i[0], 1'b0, 1'b1);
      cyc(2);
      chk("drive", st, {2'h3, i[1], i[0], 1'h1});
    end
    hbfpl_mcu_model_inst.drive(1'b1, 1'b0, 1'b1, 1'b1);
    cyc(2);
    chk("disable", st, 5'h00);
    hbfpl_mcu_model_inst.drive(1'b1, 1'b0, 1'b0, 1'b0);
    cyc(2);
    chk("sleep", st, 5'h01);
    hbfpl_mcu_model_inst.drive(1'b0, 1'b1, 1'b0, 1'b1);
    cyc(2);
  endtask
  // Short latch, held inputs, both clear edges, power cycle
  task t_short();
    for (int k = 0; k < 3; k++)
    begin
      short_detect = 1'b1;
      cyc(1);
      short_detect = 1'b0;
      cyc(1);
      chk("short", st, 5'h00);
      chk("cause", {3'h0, fault_cause}, 5'h01);
      if (k == 0) hbfpl_mcu_model_inst.pulse_disable();
      if (k == 1) hbfpl_mcu_model_inst.pulse_enable();
      if (k == 2) rst_n = 1'b0;
      cyc(3);
      chk("clear", st, k == 2 ? 5'h01 : 5'h1B);
      rst_n = 1'b1;
      cyc(2);
    end
    short_detect = 1'b1;
    hbfpl_mcu_model_inst.pulse_disable();
    cyc(3);
    chk("refault", st, 5'h00);
    short_detect = 1'b0;
    hbfpl_mcu_model_inst.pulse_disable();
    cyc(3);
    chk("reclear", st, 5'h1B);
  endtask
  task t_temp();
    temp_above_shutdown = 1'b1;
    temp_below_hysteresis = 1'b0;
    cyc(1);
    temp_above_shutdown = 1'b0;
    cyc(1);
    chk("hot", st, 5'h00);
    chk("hcause", {3'h0, fault_cause}, 5'h02);
    hbfpl_mcu_model_inst.pulse_disable();
    cyc(3);
    chk("cooling", st, 5'h01);
    temp_below_hysteresis = 1'b1;
    cyc(3);
    chk("cooled", st, 5'h1B);
  endtask
  // Die kept hot only briefly
  task t_limit();
    for (int f = 1; f >= 0; f--)
    begin
      temp_above_foldback = f[0];
      cyc(2);
      chk("fold", {4'h0, current_limit_threshold}, {4'h0, f[0]});
      current_over_foldback_limit = 1'b1;
      current_over_normal_limit = !f[0];
      cyc(1);
      current_over_foldback_limit = 1'b0;
      current_over_normal_limit = 1'b0;
      n = 0;
      m = 0;
      repeat (12)
      begin
        cyc(1);
        n += !bridge_terminal_a_oe;
        m += limit_active;
      end
      chk("offtime", n[4:0], 5'h05);
      chk("limact", m[4:0], 5'h05);
      chk("resume", st, 5'h1B);
    end
  endtask
  task t_supply();
    supply_undervoltage = 1'b1;
    cyc(2);
    chk("uv", st, 5'h00);
    supply_undervoltage = 1'b0;
    cyc(2);
    chk("uvback", st, 5'h1B);
    power_supply_input_open = 1'b1;
    cyc(2);
    chk("open", st, 5'h01);
    power_supply_input_open = 1'b0;
    cyc(2);
    chk("openback", st, 5'h1B);
  endtask
  initial
  begin
    cyc(11);
    chk("reset", st, 5'h01);
    cyc(1);
    rst_n = 1'b1;
    t_cmds();
    t_short();
    t_temp();
    t_limit();
    t_supply();
    finish_test();
  end
endmodule // tb
